// ===== design/panel_map.vh
/*
 panel_map.vh: register offsets, field positions, reset values and timing counts
 for the front-panel indicator and mode control block.
 assumes a 10 MHz system clock.
*/
`ifndef PANEL_MAP_VH
`define PANEL_MAP_VH

`define CLK_KHZ 10000

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_PROGRAM 8'h04
`define OFS_STATUS 8'h08
`define OFS_CAPTURES 8'h0c

// control register fields
`define CTL_COMM_LO 0
`define CTL_COMM_HI 2
`define CTL_FB_EN 3
`define CTL_SERVICE 4
`define CTL_TRIG_LO 5
`define CTL_TRIG_HI 6

// host comm indicator states
`define COMM_OFF 3'h0
`define COMM_INIT 3'h1
`define COMM_OK 3'h2
`define COMM_TOPO 3'h3
`define COMM_TMP_ERR 3'h4
`define COMM_NO_CONN 3'h5

// camera trigger modes
`define TRIG_SINGLE 2'h0
`define TRIG_GATED 2'h1
`define TRIG_SEQ 2'h2

// reset values
`define RST_COMM 3'h0
`define RST_FB_EN 1'h1
`define RST_SERVICE 1'h0
`define RST_TRIG 2'h1
`define RST_PROGRAM 3'h0

// times in their own units
`define T_DEBOUNCE_MS 10
`define T_LONG_MS 3000
`define T_FAIL_MS 3000
`define T_BRIEF_MS 200
`define T_PRESEL_MS 10000
`define T_FLASH_SLOW_MS 250
`define T_FLASH_FAST_MS 50
`define T_DIST_TICK_US 1000
`define T_GATE_GAP_MS 20

// cycle counts derived from the clock rate
`define C_DEBOUNCE (`T_DEBOUNCE_MS * `CLK_KHZ)
`define C_LONG (`T_LONG_MS * `CLK_KHZ)
`define C_FAIL (`T_FAIL_MS * `CLK_KHZ)
`define C_BRIEF (`T_BRIEF_MS * `CLK_KHZ)
`define C_PRESEL (`T_PRESEL_MS * `CLK_KHZ)
`define C_FLASH_SLOW (`T_FLASH_SLOW_MS * `CLK_KHZ)
`define C_FLASH_FAST (`T_FLASH_FAST_MS * `CLK_KHZ)
`define C_DIST_TICK ((`T_DIST_TICK_US * `CLK_KHZ) / 1000)
`define C_GATE_GAP (`T_GATE_GAP_MS * `CLK_KHZ)

`endif

// ===== design/button_debounce.v
/*
 button_debounce.v: three-flop synchroniser and debounce filter for one button.
 assumes an asynchronous active-high button level and a synchronous reset.
*/
`timescale 1ns/1ns
module button_debounce #(
  parameter [31:0] STABLE = 32'd100000
) (
  input wire clk_i,
  input wire rst_i,
  input wire btn_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;
  reg [31:0] cnt;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      cnt <= 32'h0;
      level_o <= 1'b0;
    end else begin
      s1 <= btn_i;
      s2 <= s1;
      s3 <= s2;
      // a new level must hold for STABLE cycles
      if (s2 != s3 || s3 == level_o) begin
        cnt <= 32'h0;
      end else if (cnt == STABLE - 32'h1) begin
        level_o <= s3;
        cnt <= 32'h0;
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
  end
endmodule // button_debounce

// ===== design/panel_control.v
/*
 panel_control.v: front-panel indicators, button function/program control and
 camera trigger sequencing, with a classic Wishbone register slave.
 assumes buttons, program-select and trigger pins are asynchronous, and marker
 results come from image processing on clk_i.
*/
// Design decisions made here: the placing of the registers and the Wishbone register port.
// Operation
// - host comm indicator dark when link down
// - green flash while starting, steady when connected
// - orange flash topology, red flash/steady errors
// - feedback LED off outside its quadrant
// - feedback flash rate follows marker distance
// - all four lit at nominal position
// - preselected function flashes, no effect yet
// - preselection ends after idle timeout
// - running function refuses process interface
// - buttons ignored in service mode
// - function runs on active program until enter
// - short or impossible exit discards, long stores
// - exit outcome shown on feedback LEDs
// - eight programs, exactly one active
// - two inputs select first four programs
// - buttons select first four programs
// - single mode: one image per trigger
// - gated mode: trigger opens and closes window
// - gated mode after reset
// - sequential mode: acquire, process, output in turn
// - feedback LEDs enabled by default, switchable
`timescale 1ns/1ns
`include "panel_map.vh"
module panel_control #(
  parameter [31:0] C_DEBOUNCE = `C_DEBOUNCE,
  parameter [31:0] C_LONG = `C_LONG,
  parameter [31:0] C_FAIL = `C_FAIL,
  parameter [31:0] C_BRIEF = `C_BRIEF,
  parameter [31:0] C_PRESEL = `C_PRESEL,
  parameter [31:0] C_FLASH_SLOW = `C_FLASH_SLOW,
  parameter [31:0] C_FLASH_FAST = `C_FLASH_FAST,
  parameter [31:0] C_DIST_TICK = `C_DIST_TICK,
  parameter [31:0] C_GATE_GAP = `C_GATE_GAP
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire btn_nav_i,
  input wire btn_enter_i,
  input wire program_select_input_a_i,
  input wire program_select_input_b_i,
  input wire trigger_i,
  input wire marker_valid_i,
  input wire marker_at_origin_i,
  input wire [3:0] marker_quadrant_i,
  input wire [7:0] marker_distance_i,
  input wire result_valid_i,
  input wire teach_possible_i,
  output reg host_comm_indicator_green_o,
  output reg host_comm_indicator_red_o,
  output reg [3:0] feedback_led_o,
  output reg [1:0] function_led_o,
  output reg [3:0] program_led_o,
  output reg capture_o,
  output wire process_suspend_o,
  output reg param_store_o,
  output reg param_discard_o,
  output reg [2:0] active_program_o,
  output wire [1:0] function_active_o
);
  localparam FS_IDLE = 2'd0;
  localparam FS_PRESEL = 2'd1;
  localparam FS_RUN = 2'd2;
  localparam FS_SIG = 2'd3;

  // control register and capture counter
  reg [2:0] comm_state;
  reg fb_enable;
  reg service_mode;
  reg [1:0] trig_mode;
  reg [15:0] capture_count;

  // flash timebase
  reg [31:0] slow_cnt;
  reg [31:0] fast_cnt;
  reg slow_ph;
  reg fast_ph;
  reg [31:0] tick_cnt;
  reg [7:0] dist_cnt;
  reg dist_ph;

  // buttons
  wire nav_db;
  wire ent_db;
  reg nav_q;
  reg ent_q;
  wire nav_press = nav_db & ~nav_q & ~service_mode;
  wire ent_press = ent_db & ~ent_q & ~service_mode;
  wire ent_lvl = ent_db & ~service_mode;

  // function state machine
  reg [1:0] fstate;
  reg [2:0] sel_idx;
  reg run_func;
  reg hold;
  reg sig_ok;
  reg [31:0] tcnt;
  reg btn_prog_set;

  // pin synchronisers
  reg [1:0] ps_s1;
  reg [1:0] ps_s2;
  reg [1:0] ps_s3;
  reg [1:0] ps_lvl;
  reg [1:0] ps_q;
  reg tr_s1;
  reg tr_s2;
  reg tr_s3;
  reg tr_lvl;
  reg tr_q;

  // acquisition
  reg window_open;
  reg busy;
  reg [31:0] gap_cnt;

  wire refuse = (fstate == FS_RUN);
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_wr = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire tr_rise = tr_lvl & ~tr_q & ~refuse;
  wire ps_chg = (ps_lvl != ps_q) & ~refuse;

  assign process_suspend_o = refuse;
  assign function_active_o = refuse ? (run_func ? 2'b10 : 2'b01) : 2'b00;

  function [31:0] count_up;
    input [31:0] cnt;
    input [31:0] lim;
    begin
      count_up = (cnt == lim - 32'h1) ? 32'h0 : cnt + 32'h1;
    end
  endfunction

  button_debounce #(.STABLE(C_DEBOUNCE)) u_nav (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .btn_i(btn_nav_i),
    .level_o(nav_db)
  );

  button_debounce #(.STABLE(C_DEBOUNCE)) u_ent (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .btn_i(btn_enter_i),
    .level_o(ent_db)
  );

  // wishbone slave
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      comm_state <= `RST_COMM;
      fb_enable <= `RST_FB_EN;
      service_mode <= `RST_SERVICE;
      trig_mode <= `RST_TRIG;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) begin
        case (wb_adr_i)
          `OFS_CONTROL: wb_dat_o <= {25'h0, trig_mode, service_mode, fb_enable, comm_state};
          `OFS_PROGRAM: wb_dat_o <= {29'h0, active_program_o};
          `OFS_STATUS: wb_dat_o <= {21'h0, active_program_o, sel_idx, refuse, busy,
                                    window_open, fstate};
          `OFS_CAPTURES: wb_dat_o <= {16'h0, capture_count};
          default: wb_dat_o <= 32'h0;
        endcase
      end
      if (wb_wr && wb_adr_i == `OFS_CONTROL) begin
        comm_state <= wb_dat_i[`CTL_COMM_HI:`CTL_COMM_LO];
        fb_enable <= wb_dat_i[`CTL_FB_EN];
        service_mode <= wb_dat_i[`CTL_SERVICE];
        trig_mode <= wb_dat_i[`CTL_TRIG_HI:`CTL_TRIG_LO];
      end
    end
  end

  // flash timebase and distance-coded rate
  always @(posedge clk_i) begin
    if (rst_i) begin
      slow_cnt <= 32'h0;
      fast_cnt <= 32'h0;
      slow_ph <= 1'b0;
      fast_ph <= 1'b0;
      tick_cnt <= 32'h0;
      dist_cnt <= 8'h0;
      dist_ph <= 1'b0;
    end else begin
      slow_cnt <= count_up(slow_cnt, C_FLASH_SLOW);
      if (slow_cnt == C_FLASH_SLOW - 32'h1) begin
        slow_ph <= ~slow_ph;
      end
      fast_cnt <= count_up(fast_cnt, C_FLASH_FAST);
      if (fast_cnt == C_FLASH_FAST - 32'h1) begin
        fast_ph <= ~fast_ph;
      end
      tick_cnt <= count_up(tick_cnt, C_DIST_TICK);
      if (tick_cnt == C_DIST_TICK - 32'h1) begin
        // half period grows with distance
        if (dist_cnt >= marker_distance_i) begin
          dist_cnt <= 8'h0;
          dist_ph <= ~dist_ph;
        end else begin
          dist_cnt <= dist_cnt + 8'h1;
        end
      end
    end
  end

  // function and program selection from the buttons
  always @(posedge clk_i) begin
    if (rst_i) begin
      nav_q <= 1'b0;
      ent_q <= 1'b0;
      fstate <= FS_IDLE;
      sel_idx <= 3'h0;
      run_func <= 1'b0;
      hold <= 1'b0;
      sig_ok <= 1'b0;
      tcnt <= 32'h0;
      btn_prog_set <= 1'b0;
      param_store_o <= 1'b0;
      param_discard_o <= 1'b0;
    end else begin
      nav_q <= nav_db;
      ent_q <= ent_db;
      btn_prog_set <= 1'b0;
      param_store_o <= 1'b0;
      param_discard_o <= 1'b0;
      case (fstate)
        FS_IDLE: begin
          tcnt <= 32'h0;
          if (nav_press) begin
            fstate <= FS_PRESEL;
            sel_idx <= 3'h0;
          end
        end
        FS_PRESEL: begin
          if (nav_press) begin
            sel_idx <= (sel_idx == 3'h5) ? 3'h0 : sel_idx + 3'h1;
            tcnt <= 32'h0;
          end else if (ent_press) begin
            tcnt <= 32'h0;
            hold <= 1'b0;
            if (sel_idx < 3'h2) begin
              run_func <= sel_idx[0];
              fstate <= FS_RUN;
            end else begin
              btn_prog_set <= 1'b1;
              fstate <= FS_IDLE;
            end
          end else if (tcnt == C_PRESEL - 32'h1) begin
            fstate <= FS_IDLE;
          end else begin
            tcnt <= tcnt + 32'h1;
          end
        end
        FS_RUN: begin
          if (ent_press) begin
            hold <= 1'b1;
          end
          if (hold & ent_lvl) begin
            if (tcnt == C_LONG - 32'h1) begin
              fstate <= FS_SIG;
              tcnt <= 32'h0;
              sig_ok <= teach_possible_i;
              param_store_o <= teach_possible_i;
              param_discard_o <= ~teach_possible_i;
            end else begin
              tcnt <= tcnt + 32'h1;
            end
          end else if (hold & ~ent_lvl) begin
            fstate <= FS_SIG;
            tcnt <= 32'h0;
            sig_ok <= 1'b0;
            param_discard_o <= 1'b1;
          end
        end
        FS_SIG: begin
          if (tcnt == (sig_ok ? C_BRIEF : C_FAIL) - 32'h1) begin
            fstate <= FS_IDLE;
          end else begin
            tcnt <= tcnt + 32'h1;
          end
        end
        default: fstate <= FS_IDLE;
      endcase
    end
  end

  // program-select and trigger pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      ps_s1 <= 2'h0;
      ps_s2 <= 2'h0;
      ps_s3 <= 2'h0;
      ps_lvl <= 2'h0;
      ps_q <= 2'h0;
      tr_s1 <= 1'b0;
      tr_s2 <= 1'b0;
      tr_s3 <= 1'b0;
      tr_lvl <= 1'b0;
      tr_q <= 1'b0;
    end else begin
      ps_s1 <= {program_select_input_b_i, program_select_input_a_i};
      ps_s2 <= ps_s1;
      ps_s3 <= ps_s2;
      if (ps_s2 == ps_s3) begin
        ps_lvl <= ps_s3;
      end
      ps_q <= ps_lvl;
      tr_s1 <= trigger_i;
      tr_s2 <= tr_s1;
      tr_s3 <= tr_s2;
      if (tr_s2 == tr_s3) begin
        tr_lvl <= tr_s3;
      end
      tr_q <= tr_lvl;
    end
  end

  // active program: one of eight
  always @(posedge clk_i) begin
    if (rst_i) begin
      active_program_o <= `RST_PROGRAM;
    end else if (btn_prog_set) begin
      active_program_o <= sel_idx - 3'h2;
    end else if (ps_chg) begin
      active_program_o <= {1'b0, ps_lvl};
    end else if (wb_wr && wb_adr_i == `OFS_PROGRAM) begin
      active_program_o <= wb_dat_i[2:0];
    end
  end

  // acquisition sequencing
  always @(posedge clk_i) begin
    if (rst_i) begin
      window_open <= 1'b0;
      busy <= 1'b0;
      gap_cnt <= 32'h0;
      capture_o <= 1'b0;
      capture_count <= 16'h0;
    end else begin
      capture_o <= 1'b0;
      window_open <= tr_lvl & ~refuse & (trig_mode != `TRIG_SINGLE);
      gap_cnt <= window_open ? count_up(gap_cnt, C_GATE_GAP) : 32'h0;
      if (result_valid_i) begin
        busy <= 1'b0;
      end
      case (trig_mode)
        `TRIG_SINGLE: begin
          if (tr_rise & ~busy) begin
            capture_o <= 1'b1;
            busy <= 1'b1;
          end
        end
        `TRIG_GATED: begin
          if (window_open && gap_cnt == 32'h0 && tr_lvl && !refuse) begin
            capture_o <= 1'b1;
            busy <= 1'b1;
          end
        end
        `TRIG_SEQ: begin
          if (window_open & tr_lvl & ~refuse & (~busy | result_valid_i)) begin
            capture_o <= 1'b1;
            busy <= 1'b1;
          end
        end
        default: capture_o <= 1'b0;
      endcase
      if (capture_o) begin
        capture_count <= capture_count + 16'h1;
      end
    end
  end

  // indicator outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      host_comm_indicator_green_o <= 1'b0;
      host_comm_indicator_red_o <= 1'b0;
      feedback_led_o <= 4'h0;
      function_led_o <= 2'h0;
      program_led_o <= 4'h0;
    end else begin
      case (comm_state)
        `COMM_INIT: begin
          host_comm_indicator_green_o <= slow_ph;
          host_comm_indicator_red_o <= 1'b0;
        end
        `COMM_OK: begin
          host_comm_indicator_green_o <= 1'b1;
          host_comm_indicator_red_o <= 1'b0;
        end
        `COMM_TOPO: begin
          host_comm_indicator_green_o <= slow_ph;
          host_comm_indicator_red_o <= slow_ph;
        end
        `COMM_TMP_ERR: begin
          host_comm_indicator_green_o <= 1'b0;
          host_comm_indicator_red_o <= slow_ph;
        end
        `COMM_NO_CONN: begin
          host_comm_indicator_green_o <= 1'b0;
          host_comm_indicator_red_o <= 1'b1;
        end
        default: begin
          host_comm_indicator_green_o <= 1'b0;
          host_comm_indicator_red_o <= 1'b0;
        end
      endcase
      if (fstate == FS_SIG) begin
        feedback_led_o <= (sig_ok ? 1'b1 : fast_ph) ? 4'hf : 4'h0;
      end else if (!fb_enable || !(window_open || busy) || !marker_valid_i) begin
        feedback_led_o <= 4'h0;
      end else if (marker_at_origin_i) begin
        feedback_led_o <= 4'hf;
      end else begin
        feedback_led_o <= marker_quadrant_i & {4{dist_ph}};
      end
      if (fstate == FS_PRESEL) begin
        function_led_o <= (sel_idx < 3'h2) ? {sel_idx[0], ~sel_idx[0]} & {2{slow_ph}}
                                           : 2'h0;
        program_led_o <= (sel_idx >= 3'h2) ? (4'h1 << (sel_idx - 3'h2)) & {4{slow_ph}}
                                           : 4'h0;
      end else begin
        function_led_o <= function_active_o;
        program_led_o <= active_program_o[2] ? 4'h0 : (4'h1 << active_program_o[1:0]);
      end
    end
  end
endmodule // panel_control

// ===== bench/panel_chk.sv
/* panel_chk: port assertions for panel_control.
   assumes rising-edge clk_i and synchronous active-high rst_i. */
`timescale 1ns/1ns
module panel_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire capture_o,
  input wire process_suspend_o,
  input wire param_store_o,
  input wire param_discard_o,
  input wire [3:0] program_led_o,
  input wire [2:0] active_program_o,
  input wire [1:0] function_active_o
);
  reg [2:0] age;
  always @(posedge clk_i) begin
    if (rst_i) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_cap_pulse; capture_o |=> !capture_o; endproperty
  a_cap_pulse: assert property (p_cap_pulse) else $error("capture pulse too long");
  property p_store_pulse; param_store_o |=> !param_store_o; endproperty
  a_store_pulse: assert property (p_store_pulse) else $error("store pulse too long");
  property p_store_excl; !(param_store_o && param_discard_o); endproperty
  a_store_excl: assert property (p_store_excl) else $error("store and discard together");
  property p_exit_param; $fell(process_suspend_o) |-> param_store_o || param_discard_o; endproperty
  a_exit_param: assert property (p_exit_param) else $error("exit without verdict");
  property p_one_func; function_active_o != 2'h3; endproperty
  a_one_func: assert property (p_one_func) else $error("two functions active");
  property p_run_nocap;
    process_suspend_o && $past(process_suspend_o) && $past(process_suspend_o, 2) |-> !capture_o;
  endproperty
  a_run_nocap: assert property (p_run_nocap) else $error("capture while suspended");
  property p_prog_led;
    age == 3'h7 && $stable(active_program_o) && active_program_o < 3'h4
      |-> program_led_o == (4'h1 << active_program_o);
  endproperty
  a_prog_led: assert property (p_prog_led) else $error("program leds wrong");
endmodule // panel_chk

// ===== bench/panel_partner.sv
/* panel_partner: operator buttons, program-select pins and trigger of the host.
   assumes its tasks are called just after a rising clk_i edge. */
`timescale 1ns/1ns
module panel_partner (
  input wire clk_i,
  output reg btn_nav_o,
  output reg btn_enter_o,
  output reg program_select_input_a_o,
  output reg program_select_input_b_o,
  output reg trigger_o
);
  initial begin
    btn_nav_o = 1'b0;
    btn_enter_o = 1'b0;
    program_select_input_a_o = 1'b0;
    program_select_input_b_o = 1'b0;
    trigger_o = 1'b0;
  end
  task press(input reg nav, input reg ent, input integer held);
    integer i;
    begin
      btn_nav_o <= nav;
      btn_enter_o <= ent;
      for (i = 0; i < held; i = i + 1) @(posedge clk_i);
      btn_nav_o <= 1'b0;
      btn_enter_o <= 1'b0;
      for (i = 0; i < 12; i = i + 1) @(posedge clk_i);
    end
  endtask
  task set_pins(input reg b, input reg a);
    begin
      program_select_input_b_o <= b;
      program_select_input_a_o <= a;
    end
  endtask
  task set_trig(input reg t);
    trigger_o <= t;
  endtask
endmodule // panel_partner

// ===== bench/testbench.sv
/* testbench: directed tests of panel_control with shortened counts.
   assumes panel_partner for buttons, pins and trigger. */
`timescale 1ns/1ns
module testbench;
  reg clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, marker_valid_i, marker_at_origin_i;
  reg result_valid_i, teach_possible_i, fb0_q;
  reg [3:0] wb_sel_i, marker_quadrant_i;
  reg [7:0] wb_adr_i, marker_distance_i;
  reg [31:0] wb_dat_i;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, nav, ent, psa, psb, trig, led_g, led_r, cap, susp, st, dis;
  wire [3:0] fb, prog_led;
  wire [1:0] fn_led, fn;
  wire [2:0] prog;
  integer ng = 0, nr = 0, nf = 0, ntog = 0, nbad = 0, ncap = 0, nst = 0, ndis = 0;
  integer tick = 0, failures = 0, n_tests = 0;
  integer s, g0, r0, c0, f0, t0, t1, b0, d0;
  reg [31:0] q;
  panel_partner u_host (.clk_i(clk_i), .btn_nav_o(nav), .btn_enter_o(ent),
    .program_select_input_a_o(psa), .program_select_input_b_o(psb), .trigger_o(trig));
  panel_control #(.C_DEBOUNCE(4), .C_LONG(50), .C_FAIL(40), .C_BRIEF(10), .C_PRESEL(60),
    .C_FLASH_SLOW(4), .C_FLASH_FAST(2), .C_DIST_TICK(2), .C_GATE_GAP(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .btn_nav_i(nav), .btn_enter_i(ent),
    .program_select_input_a_i(psa), .program_select_input_b_i(psb), .trigger_i(trig),
    .marker_valid_i(marker_valid_i), .marker_at_origin_i(marker_at_origin_i),
    .marker_quadrant_i(marker_quadrant_i), .marker_distance_i(marker_distance_i),
    .result_valid_i(result_valid_i), .teach_possible_i(teach_possible_i),
    .host_comm_indicator_green_o(led_g), .host_comm_indicator_red_o(led_r),
    .feedback_led_o(fb), .function_led_o(fn_led), .program_led_o(prog_led),
    .capture_o(cap), .process_suspend_o(susp), .param_store_o(st), .param_discard_o(dis),
    .active_program_o(prog), .function_active_o(fn));
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tick <= tick + 1;
    ng <= ng + (led_g === 1'b1);
    nr <= nr + (led_r === 1'b1);
    nf <= nf + (fb === 4'hf);
    ntog <= ntog + (fb[0] !== fb0_q);
    fb0_q <= fb[0];
    nbad <= nbad + (fb[1] === 1'b1 || fb[3] === 1'b1);
    ncap <= ncap + (cap === 1'b1);
    nst <= nst + (st === 1'b1);
    ndis <= ndis + (dis === 1'b1);
    if (tick == 12000) begin
      failures = failures + 1;
      final_report;
    end
  end
  task cyc(input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) @(posedge clk_i);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input reg we, input [7:0] a, input [31:0] d);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      cyc(2);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  task t_reset;
    begin
      rd(8'h00, 32'h28);
      rd(8'h04, 32'h0);
      rd(8'h10, 32'h0);
      $display("test reset done");
    end
  endtask
  task t_comm;
    for (s = 0; s < 8; s = s + 1) begin
      wr(8'h00, 32'h28 | s);
      cyc(3);
      g0 = ng;
      r0 = nr;
      cyc(40);
      g0 = ng - g0;
      r0 = nr - r0;
      case (s)
        1: chk(g0 > 0 && g0 < 40 && r0 == 0, 1);
        2: chk(g0 == 40 && r0 == 0, 1);
        3: chk(g0 > 0 && g0 < 40 && r0 == g0, 1);
        4: chk(g0 == 0 && r0 > 0 && r0 < 40, 1);
        5: chk(g0 == 0 && r0 == 40, 1);
        default: chk(g0 + r0, 0);
      endcase
      if (s == 7) $display("test comm done");
    end
  endtask
  task t_prog;
    begin
      u_host.set_pins(1'b1, 1'b1);
      cyc(8);
      chk(prog, 3);
      chk(prog_led, 4'h8);
      wr(8'h04, 32'h6);
      chk(prog, 6);
      chk(prog_led, 0);
      wb_sel_i <= 4'he;
      wr(8'h04, 32'h1);
      wb_sel_i <= 4'hf;
      chk(prog, 6);
      $display("test program done");
    end
  endtask
  task t_func;
    begin
      u_host.press(1'b1, 1'b0, 10);
      g0 = 0;
      for (s = 0; s < 8; s = s + 1) begin
        cyc(1);
        g0 = g0 + (fn_led === 2'h1);
      end
      chk(g0, 4);
      rd(8'h08, 32'h601);
      chk(fn, 0);
      cyc(70);
      rd(8'h08, 32'h600);
      u_host.press(1'b1, 1'b0, 10);
      u_host.press(1'b0, 1'b1, 10);
      chk(fn, 1);
      chk(fn_led, 2'h1);
      chk(susp, 1);
      c0 = ncap;
      u_host.set_trig(1'b1);
      cyc(30);
      u_host.set_trig(1'b0);
      chk(ncap - c0, 0);
      teach_possible_i <= 1'b1;
      b0 = nst;
      d0 = ndis;
      f0 = nf;
      u_host.press(1'b0, 1'b1, 70);
      chk(nst - b0, 1);
      chk(ndis - d0, 0);
      chk(nf - f0 > 0 && nf - f0 <= 12, 1);
      chk(prog, 6);
      u_host.press(1'b1, 1'b0, 10);
      u_host.press(1'b1, 1'b0, 10);
      u_host.press(1'b0, 1'b1, 10);
      chk(fn, 2);
      chk(fn_led, 2'h2);
      d0 = ndis;
      t0 = ntog;
      u_host.press(1'b0, 1'b1, 10);
      cyc(40);
      chk(ndis - d0, 1);
      chk(ntog - t0 > 4, 1);
      chk(fb, 0);
      for (s = 0; s < 3; s = s + 1) u_host.press(1'b1, 1'b0, 10);
      u_host.press(1'b0, 1'b1, 10);
      chk(prog_led, 4'h1);
      wr(8'h00, 32'h38);
      u_host.press(1'b1, 1'b0, 10);
      rd(8'h08, 32'h40);
      $display("test function done");
    end
  endtask
  task t_trig;
    begin
      wr(8'h00, 32'h08);
      c0 = ncap;
      for (s = 0; s < 3; s = s + 1) begin
        if (s == 2) result_valid_i <= 1'b1;
        u_host.set_trig(1'b1);
        cyc(1);
        result_valid_i <= 1'b0;
        cyc(20);
        u_host.set_trig(1'b0);
        cyc(10);
      end
      chk(ncap - c0, 2);
      result_valid_i <= 1'b1;
      wr(8'h00, 32'h28);
      result_valid_i <= 1'b0;
      marker_valid_i <= 1'b1;
      marker_quadrant_i <= 4'h5;
      c0 = ncap;
      b0 = nbad;
      u_host.set_trig(1'b1);
      cyc(5);
      t0 = ntog;
      cyc(64);
      t1 = ntog - t0;
      marker_distance_i <= 8'h07;
      cyc(4);
      t0 = ntog;
      cyc(64);
      chk(t1 > ntog - t0 && ntog - t0 > 0, 1);
      chk(nbad - b0, 0);
      chk(ncap - c0 >= 15 && ncap - c0 <= 18, 1);
      marker_at_origin_i <= 1'b1;
      cyc(3);
      f0 = nf;
      cyc(10);
      chk(nf - f0, 10);
      wr(8'h00, 32'h20);
      chk(fb, 0);
      wr(8'h00, 32'h28);
      marker_valid_i <= 1'b0;
      cyc(3);
      chk(fb, 0);
      u_host.set_trig(1'b0);
      cyc(5);
      c0 = ncap;
      cyc(20);
      chk(ncap - c0, 0);
      wr(8'h00, 32'h48);
      c0 = ncap;
      u_host.set_trig(1'b1);
      cyc(10);
      chk(ncap - c0, 0);
      for (s = 0; s < 3; s = s + 1) begin
        result_valid_i <= 1'b1;
        cyc(1);
        result_valid_i <= 1'b0;
        cyc(5);
      end
      chk(ncap - c0, 3);
      u_host.set_trig(1'b0);
      $display("test trigger done");
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_sel_i = 4'hf;
    {wb_cyc_i, wb_stb_i, wb_we_i, marker_valid_i, marker_at_origin_i} = 5'h0;
    {result_valid_i, teach_possible_i, fb0_q} = 3'h0;
    {wb_adr_i, wb_dat_i, marker_quadrant_i, marker_distance_i} = 52'h0;
    cyc(12);
    rst_i <= 1'b0;
    cyc(2);
    t_reset;
    t_comm;
    t_prog;
    t_func;
    t_trig;
    final_report;
  end
endmodule // testbench
bind panel_control panel_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .capture_o(capture_o),
  .process_suspend_o(process_suspend_o), .param_store_o(param_store_o),
  .param_discard_o(param_discard_o), .program_led_o(program_led_o),
  .active_program_o(active_program_o), .function_active_o(function_active_o));
